// [tb/nand_flash_model.sv]
`timescale 1ns/1ps
module nand_flash_model
  import nand_ctl_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'h3C5A_C3A5,
  parameter int BUSY_CYC = 40,
  parameter int RST_CYC = 12,
  parameter int PWR_CYC = 10
) (
  input wire logic aclk,
  input wire flash_pins_t pins,
  input wire logic force_fail,
  output logic [7:0] dq,
  output logic rb_low,
  output logic viol
);
  // ----------------------------------------------------------------------
  // Strobe-driven device; the clock times busy periods and counts cycles for the power-up check, on its falling edge so
  // status changes never race the controller's sampling edge. ID_WORD is arbitrary.
  // ----------------------------------------------------------------------
  logic [7:0] last_cmd = CMD_READ;
  logic [7:0] adr [4];
  logic fail = 1'b0;
  logic [1:0] mode = 2'd0;
  logic [15:0] src_row, dst_row, erase_blk, patch_col;
  logic [7:0] patch_dat;
  logic [7:0] stat;
  int acnt = 0, busy = 0, cyc = 0, id_idx = 0, erase_cnt = 0, prog_cnt = 0, rst_cnt = 0;
  initial viol = 1'b0;
  assign stat = {pins.wp_n, busy == 0, 5'h00, fail};
  assign dq = (!pins.ce_n && !pins.read_strobe_n) ?
    ((mode == 2'd2) ? ID_WORD[8 * id_idx[1:0] +: 8] : stat) : ~cyc[7:0];
  assign rb_low = busy != 0;
  always @(negedge aclk) begin
    cyc++;
    if (busy != 0) busy--;
  end
  always @(posedge pins.read_strobe_n) if (!pins.ce_n && mode == 2'd2) id_idx++;
  always @(negedge pins.wp_n) if (busy != 0) viol = 1'b1;
  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      if (cyc < PWR_CYC) viol = 1'b1;
      if (pins.cle && (busy == 0 || pins.dq_out == CMD_STATUS || pins.dq_out == CMD_RESET)) begin
        acnt = 0;
        id_idx = 0;
        mode = (pins.dq_out == CMD_STATUS) ? 2'd1 : (pins.dq_out == CMD_IDENT) ? 2'd2 : 2'd0;
        case (pins.dq_out)
          CMD_READ_COPY: if (last_cmd == CMD_READ) begin
            src_row = {adr[3], adr[2]};
            busy = BUSY_CYC;
          end
          CMD_PROG_CONFIRM: if (last_cmd == CMD_COPY_INPUT) begin
            dst_row = {adr[3], adr[2]};
            fail = force_fail;
            busy = BUSY_CYC;
            if (pins.wp_n) prog_cnt++;
          end
          CMD_ERASE_CONFIRM: if (last_cmd == CMD_ERASE_SETUP) begin
            erase_blk = {adr[1], adr[0]} & 16'hFFC0;
            fail = force_fail;
            busy = BUSY_CYC;
            if (pins.wp_n) erase_cnt++;
          end
          CMD_RESET: begin
            busy = RST_CYC;
            fail = 1'b0;
            rst_cnt++;
          end
          default: ;
        endcase
        if (pins.dq_out != CMD_STATUS) last_cmd = pins.dq_out;
      end else if (pins.ale) begin
        if (acnt < 4) adr[acnt] = pins.dq_out;
        acnt++;
      end else if (!pins.cle && last_cmd == CMD_COPY_INPUT) begin
        patch_col = {adr[1], adr[0]};
        patch_dat = pins.dq_out;
      end
    end
  end
endmodule // nand_flash_model

// [tb/nand_host_ctl_assertions.sv]
`timescale 1ns/1ps
module nand_host_ctl_chk
  import nand_ctl_pkg::*;
#(
  parameter int POWER_UP_WAIT = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire flash_pins_t pins,
  input wire logic ready_busy
);
  // ----------------------------------------------------------------------
  // Cycles since reset release, saturating so long runs never wrap.
  // ----------------------------------------------------------------------
  logic [15:0] up_cnt_q, up_cnt_d;
  always_comb begin
    up_cnt_d = !aresetn ? 16'h0000 : (&up_cnt_q) ? up_cnt_q : up_cnt_q + 16'h0001;
  end
  always_ff @(posedge aclk) begin
    up_cnt_q <= up_cnt_d;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence we_pulse_s;
    !pins.we_n ##1 pins.we_n [*2];
  endsequence
  sequence re_pulse_s;
    !pins.read_strobe_n ##1 pins.read_strobe_n;
  endsequence
  pins_idle_a: assert property (disable iff (1'b0) !aresetn |=> pins.ce_n && pins.we_n
    && pins.read_strobe_n && !pins.wp_n && !pins.dq_oe) else $error("pins not idle in reset");
  power_wait_a: assert property (!pins.we_n |-> up_cnt_q >= 16'(POWER_UP_WAIT))
    else $error("flash write before power-up wait");
  we_pulse_a: assert property ($fell(pins.we_n) |=> we_pulse_s)
    else $error("write strobe shape wrong");
  latch_stable_a: assert property ($rose(pins.we_n) |-> $stable({pins.cle, pins.ale, pins.dq_out}))
    else $error("cycle changed at latch edge");
  strobe_sel_a: assert property (!pins.we_n || !pins.read_strobe_n |-> !pins.ce_n)
    else $error("strobe without chip select");
  no_fight_a: assert property (!pins.read_strobe_n |-> !pins.dq_oe)
    else $error("data lines driven during read");
  re_pulse_a: assert property ($fell(pins.read_strobe_n) |=> re_pulse_s)
    else $error("read strobe shape wrong");
  wp_busy_a: assert property (!ready_busy |-> !$fell(pins.wp_n))
    else $error("write protect asserted while busy");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule // nand_host_ctl_chk

bind nand_host_ctl nand_host_ctl_chk #(.POWER_UP_WAIT(POWER_UP_WAIT)) chk_i (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .pins, .ready_busy);

// [tb/nand_host_ctl_tb_top.sv]
`timescale 1ns/1ps
module nand_host_ctl_tb_top;
  import nand_ctl_pkg::*;
  localparam logic [31:0] ID_WORD = 32'h3C5A_C3A5; // Arbitrary value.
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, force_fail = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, rb_low, viol, ready_busy;
  logic [1:0] bresp, rresp, r;
  logic [7:0] dq_in;
  flash_pins_t pins;
  int error_cnt = 0, checked = 0, rb_falls = 0;
  always #10 aclk = ~aclk;
  // Open-drain busy line with its pull-up.
  assign ready_busy = rb_low ? 1'b0 : 1'b1;
  always @(negedge ready_busy) rb_falls++;
  nand_host_ctl #(.POWER_UP_WAIT(10)) nand_host_ctl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins), .dq_in(dq_in),
    .ready_busy(ready_busy));
  nand_flash_model #(.ID_WORD(ID_WORD), .PWR_CYC(10)) nand_flash_model_i (.aclk(aclk),
    .pins(pins), .force_fail(force_fail), .dq(dq_in), .rb_low(rb_low), .viol(viol));
  // ----------------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic run_op(input op_t op, input logic wp, output logic [31:0] s);
    logic [1:0] r;
    wr(REG_CTRL, {23'h0, wp, 5'h00, op}, r);
    s = 32'h0;
    for (int n = 0; n < 2000 && !(s[STAT_DONE_BIT] === 1'b1 && s[STAT_BUSY_BIT] === 1'b0); n++)
      rd(REG_STAT, s, r);
    chk(s[STAT_DONE_BIT], 32'h1, "operation done");
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    d = 32'h0;
    for (int n = 0; n < 100 && d[STAT_INIT_BIT] !== 1'b1; n++) rd(REG_STAT, d, r);
    chk(d[STAT_INIT_BIT], 32'h1, "init flag");
    wr(REG_SRC_ROW, 32'h0000_0140, r);
    rd(REG_SRC_ROW, d, r);
    chk(d, 32'h0000_0140, "row register");
    wr(8'h1C, 32'h1, r);
    chk(r, RESP_SLVERR, "unmapped write");
    rd(8'h1C, d, r);
    chk(r, RESP_SLVERR, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_status_id();
    for (int wp = 0; wp < 2; wp++) begin
      run_op(OP_STATUS, wp[0], d);
      rd(REG_DEV_STATUS, d, r);
      chk({d[7:6], d[0]}, {wp[0], 2'b10}, "status byte");
    end
    run_op(OP_READ_ID, 1'b1, d);
    rd(REG_ID, d, r);
    chk(d, ID_WORD, "id word");
    $display("test status and id done");
  endtask
  task automatic t_erase();
    int e0, f0;
    for (int k = 0; k < 3; k++) begin
      e0 = nand_flash_model_i.erase_cnt;
      f0 = rb_falls;
      force_fail <= (k == 1);
      wr(REG_DST_ROW, 32'h0000_2A45, r);
      run_op(OP_ERASE, k < 2, d);
      chk(d[STAT_FAIL_BIT], k == 1, "erase fail flag");
      chk(nand_flash_model_i.erase_cnt - e0, k < 2, "erase count");
      chk(nand_flash_model_i.erase_blk, 32'h2A40, "erase block");
      chk(rb_falls - f0, 32'h1, "erase busy");
      rd(REG_DEV_STATUS, d, r);
      chk({d[7], d[0]}, {k < 2, k == 1}, "erase status");
    end
    force_fail <= 1'b0;
    $display("test erase done");
  endtask
  task automatic t_copyback();
    int p0, f0;
    p0 = nand_flash_model_i.prog_cnt;
    f0 = rb_falls;
    wr(REG_SRC_ROW, 32'h0000_0100, r);
    wr(REG_DST_ROW, 32'h0000_0180, r);
    wr(REG_PATCH, 32'h805C_0123, r);
    run_op(OP_COPYBACK, 1'b1, d);
    chk(d[STAT_FAIL_BIT], 32'h0, "copy fail flag");
    chk(nand_flash_model_i.prog_cnt - p0, 32'h1, "program count");
    chk(rb_falls - f0, 32'h2, "copy busy periods");
    chk(nand_flash_model_i.src_row, 32'h0100, "source row");
    chk(nand_flash_model_i.dst_row, 32'h0180, "target row");
    chk({nand_flash_model_i.patch_col, nand_flash_model_i.patch_dat}, 32'h0001_235C, "patch");
    $display("test copyback done");
  endtask
  task automatic t_reset();
    int c0, f0;
    force_fail <= 1'b1;
    run_op(OP_ERASE, 1'b1, d);
    force_fail <= 1'b0;
    c0 = nand_flash_model_i.rst_cnt;
    f0 = rb_falls;
    run_op(OP_RESET, 1'b1, d);
    run_op(OP_RESET, 1'b1, d);
    chk(nand_flash_model_i.rst_cnt - c0, 32'h2, "reset count");
    chk(rb_falls - f0, 32'h2, "reset busy");
    run_op(OP_STATUS, 1'b1, d);
    rd(REG_DEV_STATUS, d, r);
    chk(d[7:0] & 8'hC1, 32'hC0, "status after reset");
    $display("test reset done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_status_id();
    t_erase();
    t_copyback();
    t_reset();
    chk(viol, 32'h0, "far side protocol");
    final_report();
  end
  initial begin
    repeat (80000) @(posedge aclk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule // nand_host_ctl_tb_top

// [verilog/nand_ctl_pkg.sv]
package nand_ctl_pkg;

  // ----------------------------------------------------------------------
  // Flash command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_COPY = 8'h35;
  localparam logic [7:0] CMD_COPY_INPUT = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;

  // ----------------------------------------------------------------------
  // Device status byte layout
  // ----------------------------------------------------------------------
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_READY_BIT = 6;
  localparam int ST_UNPROT_BIT = 7;
  localparam logic [7:0] ST_RESET_VALUE = 8'hC0;
  localparam int ID_BYTES = 4;
  localparam int ADDR_CYCLES = 4;
  localparam int ERASE_ADDR_CYCLES = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int POWER_UP_US = 100;
  localparam int POWER_UP_CYCLES = POWER_UP_US * CLK_MHZ;
  localparam int STROBE_CYCLES = 2;

  // ----------------------------------------------------------------------
  // Own register map, byte addresses on AXI4-Lite
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SRC_ROW = 8'h04;
  localparam logic [7:0] REG_DST_ROW = 8'h08;
  localparam logic [7:0] REG_PATCH = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_ID = 8'h14;
  localparam logic [7:0] REG_DEV_STATUS = 8'h18;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_WP_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam int STAT_INIT_BIT = 3;
  localparam int STAT_PROT_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_COPYBACK,
    OP_ERASE,
    OP_READ_ID,
    OP_RESET,
    OP_STATUS
  } op_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic [7:0] dq_out;
    logic dq_oe;
  } flash_pins_t;

endpackage

// [verilog/nand_host_ctl.sv]
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module nand_host_ctl
  import nand_ctl_pkg::*;
#(
  parameter int POWER_UP_WAIT = POWER_UP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output flash_pins_t pins,
  input wire logic [7:0] dq_in,
  input wire logic ready_busy
);

  if (POWER_UP_WAIT < 1 || POWER_UP_WAIT > 8192) begin : g_bad_wait
    $error("POWER_UP_WAIT must fit the 13-bit wait counter");
  end

  typedef enum logic [3:0] {
    S_POWER,
    S_IDLE,
    S_CMD,
    S_ADDR,
    S_DATA,
    S_WAIT_BUSY,
    S_WAIT_READY,
    S_RD_STATUS,
    S_RD_ID,
    S_DONE
  } state_t;

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  state_t state_q, state_d;
  op_t op_q, op_d;
  logic [2:0] step_q, step_d;
  logic [2:0] idx_q, idx_d;
  logic [12:0] cnt_q, cnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic busy_q, busy_d, done_q, done_d, fail_q, fail_d, init_q, init_d;
  logic prot_q, prot_d;
  logic [7:0] dev_status_q, dev_status_d;
  logic [7:0] id_q [ID_BYTES];
  logic [7:0] id_d [ID_BYTES];
  flash_pins_t pins_q, pins_d;
  // Register file.
  logic [2:0] op_req_q, op_req_d;
  logic go_q, go_d, wp_en_q, wp_en_d;
  logic [15:0] src_row_q, src_row_d, dst_row_q, dst_row_d;
  logic [11:0] patch_col_q, patch_col_d;
  logic [7:0] patch_dat_q, patch_dat_d;
  logic patch_en_q, patch_en_d;
  // Bus.
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  assign pins = pins_q;
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  // Each bus cycle is split in two: strobe low for STROBE_CYCLES, then high.
  // The device latches on the rising write strobe at the end of the low half.
  always_comb begin
    logic [7:0] row [ADDR_CYCLES];
    state_d = state_q;
    op_d = op_q;
    step_d = step_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    busy_d = busy_q;
    done_d = done_q;
    fail_d = fail_q;
    init_d = init_q;
    prot_d = prot_q;
    dev_status_d = dev_status_q;
    id_d = id_q;
    pins_d = pins_q;
    pins_d.wp_n = busy_q ? pins_q.wp_n : wp_en_q;
    row[0] = 8'h00;
    row[1] = 8'h00;
    row[2] = 8'h00;
    row[3] = 8'h00;
    unique case (state_q)
      S_POWER: begin
        if (cnt_q >= 13'(POWER_UP_WAIT - 1)) begin
          init_d = 1'b1;
          state_d = S_IDLE;
        end else begin
          cnt_d = cnt_q + 13'd1;
        end
      end
      S_IDLE: begin
        if (go_q && op_req_q != 3'(OP_NONE)) begin
          op_d = op_t'(op_req_q);
          busy_d = 1'b1;
          done_d = 1'b0;
          fail_d = 1'b0;
          prot_d = 1'b0;
          step_d = 3'd0;
          state_d = S_CMD;
        end
      end
      S_CMD: begin
        // Each op is a short script indexed by step_q.
        unique case (op_q)
          OP_COPYBACK: cmd_d = (step_q == 3'd0) ? CMD_READ :
                               (step_q == 3'd1) ? CMD_READ_COPY :
                               (step_q == 3'd2) ? CMD_COPY_INPUT :
                               (step_q == 3'd3) ? CMD_COPY_INPUT :
                               (step_q == 3'd4) ? CMD_PROG_CONFIRM : CMD_STATUS;
          OP_ERASE: cmd_d = (step_q == 3'd0) ? CMD_ERASE_SETUP :
                            (step_q == 3'd1) ? CMD_ERASE_CONFIRM : CMD_STATUS;
          OP_READ_ID: cmd_d = CMD_IDENT;
          OP_RESET: cmd_d = CMD_RESET;
          default: cmd_d = CMD_STATUS;
        endcase
        pins_d.ce_n = 1'b0;
        pins_d.cle = 1'b1;
        pins_d.ale = 1'b0;
        pins_d.dq_oe = 1'b1;
        pins_d.dq_out = cmd_d;
        pins_d.we_n = 1'b0;
        cnt_d = '0;
        idx_d = '0;
        state_d = S_DATA;
      end
      S_ADDR, S_DATA: begin
        // Strobe phase: low then high, then advance.
        cnt_d = cnt_q + 13'd1;
        if (cnt_q == 13'(STROBE_CYCLES - 1)) begin
          pins_d.we_n = 1'b1;
        end else if (cnt_q == 13'(2 * STROBE_CYCLES - 1)) begin
          cnt_d = '0;
          pins_d.cle = 1'b0;
          pins_d.ale = 1'b0;
          pins_d.dq_oe = 1'b0;
          state_d = S_ADDR;
          // Address bytes for the next cycle of the current command.
          if (op_q == OP_COPYBACK) begin
            if (step_q == 3'd3) begin
              row[0] = patch_col_q[7:0];
              row[1] = {4'h0, patch_col_q[11:8]};
            end else begin
              row[2] = (step_q == 3'd0) ? src_row_q[7:0] : dst_row_q[7:0];
              row[3] = (step_q == 3'd0) ? src_row_q[15:8] : dst_row_q[15:8];
            end
          end else if (op_q == OP_ERASE) begin
            row[0] = {dst_row_q[7:6], 6'h00};
            row[1] = dst_row_q[15:8];
          end
          if (state_q == S_DATA && pins_q.cle) begin
            idx_d = '0;
          end else begin
            idx_d = idx_q + 3'd1;
          end
          if (next_is_addr(op_q, step_q, idx_d, patch_en_q, pins_q.cle)) begin
            pins_d.ale = !addr_is_data(op_q, step_q, idx_d);
            pins_d.dq_oe = 1'b1;
            pins_d.dq_out = addr_is_data(op_q, step_q, idx_d) ? patch_dat_q :
              ((op_q == OP_READ_ID) ? 8'h00 : row[idx_d[1:0]]);
            pins_d.we_n = 1'b0;
          end else begin
            step_d = step_q + 3'd1;
            state_d = after_cmd(op_q, step_q, patch_en_q, pins_q.cle);
            idx_d = '0;
          end
        end
      end
      S_WAIT_BUSY: begin
        // Busy may take a few cycles to fall; a timeout stands in for a miss.
        cnt_d = cnt_q + 13'd1;
        if (!ready_busy || cnt_q == 13'd16) begin
          cnt_d = '0;
          state_d = S_WAIT_READY;
        end
      end
      S_WAIT_READY: begin
        if (ready_busy) begin
          if (op_q == OP_RESET) begin
            dev_status_d = ST_RESET_VALUE;
            state_d = S_DONE;
          end else begin
            state_d = S_CMD;
          end
        end
      end
      S_RD_STATUS, S_RD_ID: begin
        cnt_d = cnt_q + 13'd1;
        if (cnt_q == 13'd0) begin
          pins_d.read_strobe_n = 1'b0;
        end else if (cnt_q == 13'(STROBE_CYCLES)) begin
          pins_d.read_strobe_n = 1'b1;
          cnt_d = '0;
          if (state_q == S_RD_STATUS) begin
            dev_status_d = dq_in;
            if (!dq_in[ST_READY_BIT]) begin
              state_d = S_RD_STATUS;
            end else begin
              fail_d = dq_in[ST_FAIL_BIT];
              prot_d = !dq_in[ST_UNPROT_BIT];
              state_d = S_DONE;
            end
          end else begin
            id_d[idx_q[1:0]] = dq_in;
            idx_d = idx_q + 3'd1;
            if (idx_q == 3'(ID_BYTES - 1)) begin
              state_d = S_DONE;
            end
          end
        end
      end
      S_DONE: begin
        pins_d.ce_n = 1'b1;
        busy_d = 1'b0;
        done_d = 1'b1;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Whether another address or data cycle follows in the current command.
  function automatic logic next_is_addr(op_t op, logic [2:0] st, logic [2:0] i, logic pe,
                                        logic was_cmd);
    logic r;
    r = 1'b0;
    unique case (op)
      OP_COPYBACK: r = (st == 3'd0 || st == 3'd2) ? (i < 3'(ADDR_CYCLES)) :
                       (st == 3'd3) ? (pe && i < 3'd3) : 1'b0;
      OP_ERASE: r = (st == 3'd0) && (i < 3'(ERASE_ADDR_CYCLES));
      OP_READ_ID: r = (i < 3'd1) && was_cmd;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic addr_is_data(op_t op, logic [2:0] st, logic [2:0] i);
    return (op == OP_COPYBACK) && (st == 3'd3) && (i == 3'd2);
  endfunction

  function automatic state_t after_cmd(op_t op, logic [2:0] st, logic pe, logic was_cmd);
    state_t s;
    s = S_CMD;
    unique case (op)
      OP_COPYBACK: s = (st == 3'd1 || st == 3'd4) ? S_WAIT_BUSY :
                       (st == 3'd5) ? S_RD_STATUS : S_CMD;
      OP_ERASE: s = (st == 3'd1) ? S_WAIT_BUSY : (st == 3'd2) ? S_RD_STATUS : S_CMD;
      OP_READ_ID: s = S_RD_ID;
      OP_RESET: s = S_WAIT_BUSY;
      default: s = S_RD_STATUS;
    endcase
    if (op == OP_COPYBACK && st == 3'd2 && !pe) begin
      s = S_CMD;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------------
  always_comb begin
    logic wr;
    aw_hold_d = aw_hold_q || (s_axi_awvalid && s_axi_awready);
    w_hold_d = w_hold_q || (s_axi_wvalid && s_axi_wready);
    awaddr_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
    wdata_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    op_req_d = op_req_q;
    go_d = 1'b0;
    wp_en_d = wp_en_q;
    src_row_d = src_row_q;
    dst_row_d = dst_row_q;
    patch_col_d = patch_col_q;
    patch_dat_d = patch_dat_q;
    patch_en_d = patch_en_q;
    wr = aw_hold_q && w_hold_q && !bvalid_q;
    if (wr) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (awaddr_q)
        REG_CTRL: begin
          op_req_d = wdata_q[CTRL_OP_LSB +: CTRL_OP_W];
          wp_en_d = wdata_q[CTRL_WP_BIT];
          go_d = !busy_q;
        end
        REG_SRC_ROW: src_row_d = wdata_q[15:0];
        REG_DST_ROW: dst_row_d = wdata_q[15:0];
        REG_PATCH: begin
          patch_col_d = wdata_q[11:0];
          patch_dat_d = wdata_q[23:16];
          patch_en_d = wdata_q[31];
        end
        REG_STAT, REG_ID, REG_DEV_STATUS: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: rdata_d = {23'h0, wp_en_q, 5'h0, op_req_q};
        REG_SRC_ROW: rdata_d = {16'h0, src_row_q};
        REG_DST_ROW: rdata_d = {16'h0, dst_row_q};
        REG_PATCH: rdata_d = {patch_en_q, 7'h0, patch_dat_q, 4'h0, patch_col_q};
        REG_STAT: rdata_d = {27'h0, prot_q, init_q, fail_q, done_q, busy_q};
        REG_ID: rdata_d = {id_q[3], id_q[2], id_q[1], id_q[0]};
        REG_DEV_STATUS: rdata_d = {24'h0, dev_status_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_POWER;
      op_q <= OP_NONE;
      step_q <= '0;
      idx_q <= '0;
      cnt_q <= '0;
      cmd_q <= CMD_READ;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      init_q <= 1'b0;
      prot_q <= 1'b0;
      dev_status_q <= ST_RESET_VALUE;
      id_q <= '{default: 8'h00};
      pins_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                  wp_n: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
      op_req_q <= '0;
      go_q <= 1'b0;
      wp_en_q <= 1'b0;
      src_row_q <= '0;
      dst_row_q <= '0;
      patch_col_q <= '0;
      patch_dat_q <= '0;
      patch_en_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      step_q <= step_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      busy_q <= busy_d;
      done_q <= done_d;
      fail_q <= fail_d;
      init_q <= init_d;
      prot_q <= prot_d;
      dev_status_q <= dev_status_d;
      id_q <= id_d;
      pins_q <= pins_d;
      op_req_q <= op_req_d;
      go_q <= go_d;
      wp_en_q <= wp_en_d;
      src_row_q <= src_row_d;
      dst_row_q <= dst_row_d;
      patch_col_q <= patch_col_d;
      patch_dat_q <= patch_dat_d;
      patch_en_q <= patch_en_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule // nand_host_ctl
